// *** hw/cdr_dev.sv ***
// device end: two-wire slave, control registers and lock indication
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cdr_dev (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  cdr_if.dev bus,
  input wire logic addr_select_in,
  input wire logic [11:0] freq_error_ppm_in,
  input wire logic harmonic_hit_in,
  input wire logic recovered_data_in,
  output logic lock_lost_indicator_out,
  output logic acquire_restart_out,
  output logic harmonic_enable_out,
  output logic [2:0] recovery_mode_select_out,
  output logic rate_measure_enable_out,
  output logic reference_buffer_powerdown_out,
  output logic data_driver_off_out,
  output logic clock_driver_off_out,
  output logic serial_data_output_out
);
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic scl_f;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic sda_f;
    logic adr_s1;
    logic adr_s2;
    cdr_pkg::cdr_dev_st_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic [7:0] mode_reg;
    logic [7:0] ind_reg;
    logic [7:0] ref_reg;
    logic [7:0] out_reg;
    logic locked;
    logic sticky;
    logic lol_pin;
    logic restart;
    logic harm_en;
    logic clk_off;
    logic dout;
  } cdr_dev_s;

  cdr_dev_s q;
  cdr_dev_s d;
  logic new_scl;
  logic new_sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic clr;
  logic loss;
  logic [7:0] rd_val;
  logic [7:0] next_ptr;

  function automatic logic [7:0] read_reg(input cdr_dev_s s, input logic [7:0] sub);
    logic [7:0] v;
    v = 8'h00;
    case (sub)
      cdr_pkg::SUB_STATUS: begin
        v[cdr_pkg::STICKY_BIT] = s.sticky;
        v[cdr_pkg::LIVE_BIT] = ~s.locked;
      end
      cdr_pkg::SUB_MODE: v = s.mode_reg;
      cdr_pkg::SUB_IND: v = s.ind_reg;
      cdr_pkg::SUB_REFBUF: v = s.ref_reg;
      cdr_pkg::SUB_OUT: v = s.out_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  function automatic logic sub_valid(input logic [7:0] sub);
    return (sub == cdr_pkg::SUB_STATUS) || (sub == cdr_pkg::SUB_MODE) ||
           (sub == cdr_pkg::SUB_IND) || (sub == cdr_pkg::SUB_REFBUF) ||
           (sub == cdr_pkg::SUB_OUT);
  endfunction : sub_valid

  always_comb begin
    d = q;
    clr = 1'b0;
    rd_val = 8'h00;
    next_ptr = q.ptr;
    // stage one feeds stage two only; the filter waits for two equal samples
    d.scl_s1 = bus.scl; // R24
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = bus.sda; // R24
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.adr_s1 = addr_select_in;
    d.adr_s2 = q.adr_s1;
    new_scl = (q.scl_s2 == q.scl_s3) ? q.scl_s3 : q.scl_f;
    new_sda = (q.sda_s2 == q.sda_s3) ? q.sda_s3 : q.sda_f;
    d.scl_f = new_scl;
    d.sda_f = new_sda;
    scl_rise = new_scl & ~q.scl_f;
    scl_fall = ~new_scl & q.scl_f;
    start_cond = q.scl_f & new_scl & q.sda_f & ~new_sda;
    stop_cond = q.scl_f & new_scl & ~q.sda_f & new_sda;
    if (start_cond) begin
      d.st = cdr_pkg::D_ADDR; // R15
      d.cnt = 4'h0;
      d.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      d.st = cdr_pkg::D_IDLE; // R15
      d.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      if (q.st == cdr_pkg::D_ADDR || q.st == cdr_pkg::D_SUB || q.st == cdr_pkg::D_WDATA) begin
        d.sh = {q.sh[6:0], new_sda}; // R13
        d.cnt = q.cnt + 4'h1;
      end else if (q.st == cdr_pkg::D_RDATA) begin
        d.cnt = q.cnt + 4'h1;
      end else if (q.st == cdr_pkg::D_RDATA_ACK) begin
        d.mack = ~new_sda;
      end
    end else if (scl_fall) begin
      unique case (q.st)
        cdr_pkg::D_IDLE: d.sda_oe_n = 1'b1;
        cdr_pkg::D_ADDR: begin
          if (q.cnt == cdr_pkg::BITS_PER_BYTE) begin
            if (q.sh[7:1] == {cdr_pkg::SLAVE_ADDR_HI, q.adr_s2}) begin // R11
              d.sda_oe_n = 1'b0; // R13
              d.rw = q.sh[0]; // R12
              d.st = cdr_pkg::D_ADDR_ACK;
            end else begin
              d.st = cdr_pkg::D_IDLE; // R13
            end
          end
        end
        cdr_pkg::D_SUB: begin
          if (q.cnt == cdr_pkg::BITS_PER_BYTE) begin
            if (sub_valid(q.sh)) begin
              d.ptr = q.sh; // R14
              d.sda_oe_n = 1'b0;
              d.st = cdr_pkg::D_SUB_ACK;
            end else begin
              d.st = cdr_pkg::D_IDLE; // R16
            end
          end
        end
        cdr_pkg::D_WDATA: begin
          if (q.cnt == cdr_pkg::BITS_PER_BYTE) begin
            case (q.ptr)
              cdr_pkg::SUB_MODE: begin
                d.mode_reg = q.sh; // R19 R21
                clr = q.mode_reg[cdr_pkg::CLR_BIT] & ~q.sh[cdr_pkg::CLR_BIT]; // R02
              end
              cdr_pkg::SUB_IND: d.ind_reg = q.sh;
              cdr_pkg::SUB_REFBUF: d.ref_reg = q.sh; // R20
              cdr_pkg::SUB_OUT: d.out_reg = q.sh;
              default: d.ind_reg = q.ind_reg;
            endcase
            // bytes written past the top are acknowledged and dropped
            if (q.ptr <= cdr_pkg::SUB_TOP) begin
              d.ptr = q.ptr + 8'h01; // R14
            end
            d.sda_oe_n = 1'b0;
            d.st = cdr_pkg::D_WDATA_ACK;
          end
        end
        cdr_pkg::D_ADDR_ACK: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            rd_val = read_reg(q, q.ptr);
            d.sh = rd_val;
            d.sda_oe_n = rd_val[7];
            d.st = cdr_pkg::D_RDATA;
          end else begin
            d.sda_oe_n = 1'b1;
            d.st = cdr_pkg::D_SUB;
          end
        end
        cdr_pkg::D_SUB_ACK, cdr_pkg::D_WDATA_ACK: begin
          d.sda_oe_n = 1'b1;
          d.cnt = 4'h0;
          d.st = cdr_pkg::D_WDATA;
        end
        cdr_pkg::D_RDATA: begin
          if (q.cnt == cdr_pkg::BITS_PER_BYTE) begin
            d.sda_oe_n = 1'b1;
            d.st = cdr_pkg::D_RDATA_ACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe_n = q.sh[6];
          end
        end
        cdr_pkg::D_RDATA_ACK: begin
          if (q.mack) begin
            if (q.ptr < cdr_pkg::SUB_TOP) begin
              next_ptr = q.ptr + 8'h01; // R14
            end
            // the pointer parks on the top register until the master stops
            d.ptr = next_ptr; // R17
            rd_val = read_reg(q, next_ptr);
            d.sh = rd_val;
            d.sda_oe_n = rd_val[7];
            d.cnt = 4'h0;
            d.st = cdr_pkg::D_RDATA;
          end else begin
            d.st = cdr_pkg::D_IDLE;
          end
        end
        default: begin
          d.st = cdr_pkg::D_IDLE;
          d.sda_oe_n = 1'b1;
        end
      endcase
    end
    // harmonic timing is owned by the upstream detector, only its hit is gated
    d.harm_en = (q.mode_reg[cdr_pkg::MODE_LSB +: 3] != cdr_pkg::MODE_LTR); // R07 R06
    loss = q.locked & ((freq_error_ppm_in > cdr_pkg::PPM_LOSE) |
                       (q.harm_en & harmonic_hit_in)); // R23 R05
    d.locked = q.locked ? ~loss : (freq_error_ppm_in < cdr_pkg::PPM_LOCK); // R23
    d.restart = loss; // R05
    d.sticky = loss | (q.sticky & ~clr); // R01 R02
    d.lol_pin = q.ind_reg[cdr_pkg::IND_BIT] ? d.sticky : ~d.locked; // R03 R04
    d.clk_off = q.out_reg[cdr_pkg::COFF_BIT] | q.out_reg[cdr_pkg::DOFF_BIT]; // R08 R09
    if (q.out_reg[cdr_pkg::DOFF_BIT]) begin
      d.dout = 1'b0; // R08
    end else if (q.out_reg[cdr_pkg::SQ_BIT]) begin
      d.dout = q.out_reg[cdr_pkg::POL_BIT]; // R10
    end else begin
      d.dout = recovered_data_in ^ q.out_reg[cdr_pkg::POL_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.scl_f <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.sda_f <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.st <= cdr_pkg::D_IDLE;
      q.mode_reg <= cdr_pkg::RST_MODE;
      q.ind_reg <= cdr_pkg::RST_IND;
      q.ref_reg <= cdr_pkg::RST_REFBUF;
      q.out_reg <= cdr_pkg::RST_OUT;
      q.lol_pin <= 1'b1;
      q.harm_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe_n = q.sda_oe_n;
  assign lock_lost_indicator_out = q.lol_pin;
  assign acquire_restart_out = q.restart;
  assign harmonic_enable_out = q.harm_en;
  assign recovery_mode_select_out = q.mode_reg[cdr_pkg::MODE_LSB +: 3];
  assign rate_measure_enable_out = q.mode_reg[cdr_pkg::MEAS_BIT];
  assign reference_buffer_powerdown_out = q.ref_reg[cdr_pkg::REFPD_BIT];
  assign data_driver_off_out = q.out_reg[cdr_pkg::DOFF_BIT];
  assign clock_driver_off_out = q.clk_off;
  assign serial_data_output_out = q.dout;
endmodule : cdr_dev
`default_nettype wire

// *** hw/cdr_pkg.sv ***
// constants, register map and state types for the cdr control port
// Summary of operation
// R01: any lock loss sets sticky lock-lost bit
// R02: write one then zero clears sticky bit
// R03: indicator mode one mirrors sticky bit on pin
// R04: indicator mode zero shows acquisition in progress
// R05: harmonic hit restarts acquisition, raises indicator
// R06: harmonic detection bounded by upstream detector timing
// R07: harmonic detector off in lock-to-reference mode
// R08: output bits power down data, clock drivers
// R09: data driver off also turns clock off
// R10: squelch forces data to polarity constant
// R11: slave address six fixed bits plus pin
// R12: eighth bit one reads, zero writes
// R13: msb first, ninth clock acknowledge, others idle
// R14: second byte subaddress, auto-increment after each byte
// R15: out-of-sequence start or stop returns idle
// R16: invalid subaddress gets no acknowledge, idle
// R17: reads past top repeat highest register
// R18: master one start/stop per clock high
// R19: mode field value two selects lock-to-reference
// R20: reference buffer powerdown bit zero powers buffer
// R21: rate measure enable bit enables measurement
// R22: software never combines reference lock and measurement
// R23: lock below 250 ppm, lose above 1000
// R24: serial inputs synchronised and filtered before use
package cdr_pkg;
  localparam logic [7:0] SUB_STATUS = 8'h06;
  localparam logic [7:0] SUB_MODE = 8'h08;
  localparam logic [7:0] SUB_IND = 8'h09;
  localparam logic [7:0] SUB_REFBUF = 8'h0A;
  localparam logic [7:0] SUB_OUT = 8'h1E;
  localparam logic [7:0] SUB_TOP = 8'h1E;
  localparam int STICKY_BIT = 2;
  localparam int LIVE_BIT = 1;
  localparam int CLR_BIT = 2;
  localparam int MODE_LSB = 4;
  localparam int MEAS_BIT = 1;
  localparam int IND_BIT = 4;
  localparam int REFPD_BIT = 2;
  localparam int DOFF_BIT = 4;
  localparam int COFF_BIT = 3;
  localparam int SQ_BIT = 5;
  localparam int POL_BIT = 1;
  localparam logic [2:0] MODE_LTR = 3'h2;
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h20;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_IND = 8'h00;
  localparam logic [7:0] RST_REFBUF = 8'h04;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [11:0] PPM_LOCK = 12'h0FA;
  localparam logic [11:0] PPM_LOSE = 12'h3E8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_QUARTER_NS = 500;
  localparam logic [4:0] QTR_CYCLES =
    5'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] H_CMD = 2'h0;
  localparam logic [1:0] H_TX = 2'h1;
  localparam logic [1:0] H_RX = 2'h2;
  localparam logic [1:0] H_STAT = 2'h3;
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_STOP = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam int NACK_BIT = 2;
  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_ADDR = 4'h1, D_ADDR_ACK = 4'h3, D_SUB = 4'h2, D_SUB_ACK = 4'h6,
    D_WDATA = 4'h7, D_WDATA_ACK = 4'h5, D_RDATA = 4'h4, D_RDATA_ACK = 4'hC
  } cdr_dev_st_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h3, H_STOP = 2'h2
  } cdr_host_st_e;
endpackage : cdr_pkg

// *** hw/cdr_if.sv ***
// two-wire link between the cdr control port and its bus master
`timescale 1ns/1ps
`default_nettype none
interface cdr_if;
  logic scl;
  logic sda;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  // open drain: line is low when any enabled driver pulls low
  assign sda = ~((~host_sda_oe_n & ~host_sda_out) | (~dev_sda_oe_n & ~dev_sda_out));
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
  modport host (output scl, input sda, output host_sda_out, output host_sda_oe_n);
endinterface : cdr_if
`default_nettype wire

// *** hw/cdr_host.sv ***
// master end: command registers driving start, stop, byte write and byte read
`timescale 1ns/1ps
`default_nettype none
module cdr_host (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  cdr_if.host bus,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  typedef struct packed {
    cdr_pkg::cdr_host_st_e st;
    logic [1:0] ph;
    logic [4:0] tick;
    logic [3:0] bits;
    logic op_rd;
    logic mnack;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sack_n;
    logic busy;
    logic scl;
    logic sda_oe_n;
    logic sda_s1;
    logic sda_s2;
    logic [7:0] rdata;
  } cdr_host_s;

  cdr_host_s q;
  cdr_host_s d;
  logic bit_out;
  logic last;

  always_comb begin
    d = q;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    last = (q.bits == cdr_pkg::BITS_PER_BYTE);
    bit_out = last ? (~q.op_rd | q.mnack) : (q.op_rd | q.tx[7]); // R13
    d.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        cdr_pkg::H_TX: d.rdata = q.tx;
        cdr_pkg::H_RX: d.rdata = q.rx;
        cdr_pkg::H_STAT: d.rdata = {6'h00, q.sack_n, q.busy};
        default: d.rdata = 8'h00;
      endcase
    end
    // commands and data written while busy are ignored
    if (wr_in && addr_in == cdr_pkg::H_TX && !q.busy) begin
      d.tx = wdata_in;
    end
    if (wr_in && addr_in == cdr_pkg::H_CMD && !q.busy) begin
      d.busy = 1'b1;
      d.ph = 2'h0;
      d.tick = 5'h00;
      d.bits = 4'h0;
      d.scl = 1'b0;
      d.mnack = wdata_in[cdr_pkg::NACK_BIT];
      d.op_rd = (wdata_in[1:0] == cdr_pkg::OP_READ); // R12
      unique case (wdata_in[1:0])
        cdr_pkg::OP_START: d.st = cdr_pkg::H_START;
        cdr_pkg::OP_STOP: d.st = cdr_pkg::H_STOP;
        cdr_pkg::OP_WRITE, cdr_pkg::OP_READ: d.st = cdr_pkg::H_BIT;
      endcase
    end else if (q.st != cdr_pkg::H_IDLE) begin
      d.tick = q.tick + 5'h01;
      if (q.tick == cdr_pkg::QTR_CYCLES - 5'h01) begin
        d.tick = 5'h00;
        d.ph = q.ph + 2'h1;
        // sda only moves while scl is low, except the start and stop edges
        unique case (q.ph)
          2'h0: begin
            if (q.st == cdr_pkg::H_START) d.sda_oe_n = 1'b1;
            else if (q.st == cdr_pkg::H_STOP) d.sda_oe_n = 1'b0;
            else d.sda_oe_n = bit_out;
          end
          2'h1: d.scl = 1'b1;
          2'h2: begin
            if (q.st == cdr_pkg::H_START) d.sda_oe_n = 1'b0; // R18
            else if (q.st == cdr_pkg::H_STOP) d.sda_oe_n = 1'b1; // R18
            else if (!last) d.rx = {q.rx[6:0], q.sda_s2};
            else if (!q.op_rd) d.sack_n = q.sda_s2;
          end
          2'h3: begin
            if (q.st == cdr_pkg::H_BIT) begin
              d.scl = 1'b0;
              d.bits = q.bits + 4'h1;
              d.tx = {q.tx[6:0], 1'b0};
            end
            if (q.st != cdr_pkg::H_BIT || last) begin
              d.st = cdr_pkg::H_IDLE;
              d.busy = 1'b0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= cdr_pkg::H_IDLE;
      q.scl <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.scl = q.scl;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe_n = q.sda_oe_n;
  assign rdata_out = q.rdata;
endmodule : cdr_host
`default_nettype wire

// *** bench/cdr_checker.sv ***
// assertions on the two-wire link and the device control outputs
`timescale 1ns/1ps
`default_nettype none
module cdr_checker (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl,
  input wire logic dev_sda_oe_n,
  input wire logic [11:0] freq_error_ppm_in,
  input wire logic harmonic_hit_in,
  input wire logic lock_lost_indicator_out,
  input wire logic acquire_restart_out,
  input wire logic harmonic_enable_out,
  input wire logic [2:0] recovery_mode_select_out,
  input wire logic data_driver_off_out,
  input wire logic clock_driver_off_out,
  input wire logic serial_data_output_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  property p_restart;
    acquire_restart_out |-> lock_lost_indicator_out;
  endproperty
  a_restart: assert property (p_restart) else $error("restart without indicator");
  property p_harm_off;
    recovery_mode_select_out == 3'h2 && $stable(recovery_mode_select_out) |-> !harmonic_enable_out;
  endproperty
  a_harm_off: assert property (p_harm_off) else $error("harmonic on in ref mode");
  property p_harm_on;
    recovery_mode_select_out != 3'h2 && $stable(recovery_mode_select_out) |-> harmonic_enable_out;
  endproperty
  a_harm_on: assert property (p_harm_on) else $error("harmonic off in normal mode");
  property p_hit;
    harmonic_enable_out && harmonic_hit_in |-> ##[0:3] lock_lost_indicator_out;
  endproperty
  a_hit: assert property (p_hit) else $error("harmonic hit ignored");
  // two samples, so a one-cycle glitch on the error input is not judged
  property p_err;
    freq_error_ppm_in > 12'h3E8 ##1 freq_error_ppm_in > 12'h3E8 |-> ##[0:3] lock_lost_indicator_out;
  endproperty
  a_err: assert property (p_err) else $error("large error kept lock");
  property p_clk_off;
    data_driver_off_out && $past(data_driver_off_out) |-> clock_driver_off_out;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock driver on with data off");
  property p_dout_off;
    data_driver_off_out && $past(data_driver_off_out) |-> !serial_data_output_out;
  endproperty
  a_dout_off: assert property (p_dout_off) else $error("data out with driver off");
  property p_sda_chg;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("device sda moved while scl high");
endmodule : cdr_checker
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] sub, val;
    logic [2:0] mode;
    logic meas, refpd, doff, coff, sdo;
  } cdr_row_s;
  localparam cdr_row_s ROWS [8] = '{
    '{8'h08, 8'h20, 3'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1},
    '{8'h08, 8'h02, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1},
    '{8'h0A, 8'h00, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
    '{8'h1E, 8'h10, 3'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0},
    '{8'h1E, 8'h08, 3'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
    '{8'h1E, 8'h22, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
    '{8'h1E, 8'h20, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h1E, 8'h02, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0}};
  logic clk_sys_in, rst_in, wr, rd, asel, hit, rdat;
  logic lli, acq, harm, meas, refpd, doff, coff, sdo;
  logic [1:0] addr;
  logic [2:0] mode;
  logic [7:0] wdata, rdata, d, st, aw, ar;
  logic [8:0] sh;
  logic [11:0] ferr;
  int err_count, n_tests, n_restart;
  assign aw = {cdr_pkg::SLAVE_ADDR_HI, asel, 1'h0};
  assign ar = {cdr_pkg::SLAVE_ADDR_HI, asel, 1'h1};
  cdr_if cdr_if_i ();
  cdr_host cdr_host_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(cdr_if_i),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
  cdr_dev cdr_dev_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(cdr_if_i),
    .addr_select_in(asel), .freq_error_ppm_in(ferr), .harmonic_hit_in(hit),
    .recovered_data_in(rdat), .lock_lost_indicator_out(lli), .acquire_restart_out(acq),
    .harmonic_enable_out(harm), .recovery_mode_select_out(mode),
    .rate_measure_enable_out(meas), .reference_buffer_powerdown_out(refpd),
    .data_driver_off_out(doff), .clock_driver_off_out(coff), .serial_data_output_out(sdo));
  cdr_checker cdr_checker_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl(cdr_if_i.scl),
    .dev_sda_oe_n(cdr_if_i.dev_sda_oe_n), .freq_error_ppm_in(ferr), .harmonic_hit_in(hit),
    .lock_lost_indicator_out(lli), .acquire_restart_out(acq), .harmonic_enable_out(harm),
    .recovery_mode_select_out(mode), .data_driver_off_out(doff),
    .clock_driver_off_out(coff), .serial_data_output_out(sdo));
  // wire monitor: last nine bits seen at scl rise, ack bit last
  always @(posedge cdr_if_i.scl) sh <= {sh[7:0], cdr_if_i.sda};
  // counts restart pulses so a missed or doubled acquisition restart shows
  always @(posedge clk_sys_in) begin
    if (rst_in) n_restart <= 0;
    else if (acq === 1'h1) n_restart <= n_restart + 1;
  end
  initial begin
    clk_sys_in = 1'h0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task hw(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk_sys_in);
    wr <= 1'h0;
  endtask : hw
  task hr(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys_in);
    rd <= 1'h0;
    #1 v = rdata;
  endtask : hr
  task op(input logic [7:0] c);
    int i;
    hw(2'h0, c);
    for (i = 0; i < 3000; i++) begin
      hr(2'h3, st);
      if (st[0] === 1'h0) break;
    end
    if (i == 3000) begin
      err_count++;
      $display("Error at %0t: host stuck busy", $time);
      report_and_stop();
    end
  endtask : op
  task sb(input logic [7:0] b, input logic nk);
    hw(2'h1, b);
    op({6'h0, cdr_pkg::OP_WRITE});
    chk({8'h00, st[1]}, {8'h00, nk});
    chk(sh, {b, nk});
  endtask : sb
  task rb(input logic nk, input logic [7:0] e);
    op({5'h0, nk, cdr_pkg::OP_READ});
    hr(2'h2, d);
    chk({1'h0, d}, {1'h0, e});
    chk(sh, {e, nk});
  endtask : rb
  task sr;
    op({6'h0, cdr_pkg::OP_START});
  endtask : sr
  task sp;
    op({6'h0, cdr_pkg::OP_STOP});
    repeat (10) @(posedge clk_sys_in);
  endtask : sp
  task wreg(input logic [7:0] s, input logic [7:0] v);
    sr();
    sb(aw, 1'h0);
    sb(s, 1'h0);
    sb(v, 1'h0);
    sp();
  endtask : wreg
  task rhead(input logic [7:0] s);
    sr();
    sb(aw, 1'h0);
    sb(s, 1'h0);
    sr();
    sb(ar, 1'h0);
  endtask : rhead
  task pulse;
    @(posedge clk_sys_in);
    hit <= 1'h1;
    @(posedge clk_sys_in);
    hit <= 1'h0;
    repeat (8) @(posedge clk_sys_in);
  endtask : pulse
  // reset is released by the edge that samples it for the fifth time
  task do_reset;
    rst_in <= 1'h1;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    #1 chk({lli, refpd, doff, coff, sdo, acq, cdr_if_i.scl, cdr_if_i.sda, harm}, 9'h187);
  endtask : do_reset
  initial begin
    {wr, rd, asel, hit, addr, wdata, ferr} = '0;
    rdat = 1'h1;
    err_count = 0;
    n_tests = 0;
    do_reset();
    repeat (10) @(posedge clk_sys_in);
    foreach (ROWS[i]) begin
      wreg(ROWS[i].sub, ROWS[i].val);
      chk({mode, meas, refpd, doff, coff, sdo, harm}, {ROWS[i][7:0], ROWS[i].mode != 3'h2});
    end
    chk({8'h00, lli}, 9'h000);
    wreg(8'h08, 8'h04);
    wreg(8'h08, 8'h00);
    rhead(8'h06);
    rb(1'h1, 8'h00);
    sp();
    ferr <= 12'h7D0;
    repeat (10) @(posedge clk_sys_in);
    chk({8'h00, lli}, 9'h001);
    chk(9'(n_restart), 9'h001);
    ferr <= 12'h000;
    repeat (10) @(posedge clk_sys_in);
    chk({8'h00, lli}, 9'h000);
    rhead(8'h06);
    rb(1'h1, 8'h04);
    sp();
    wreg(8'h09, 8'h10);
    chk({8'h00, lli}, 9'h001);
    wreg(8'h08, 8'h04);
    wreg(8'h08, 8'h00);
    chk({8'h00, lli}, 9'h000);
    pulse();
    chk({8'h00, lli}, 9'h001);
    chk(9'(n_restart), 9'h002);
    wreg(8'h09, 8'h00);
    chk({8'h00, lli}, 9'h000);
    // clear while staying in reference mode; measurement stays off there
    wreg(8'h08, 8'h24);
    wreg(8'h08, 8'h20);
    pulse();
    rhead(8'h06);
    rb(1'h1, 8'h00);
    chk(9'(n_restart), 9'h002);
    sp();
    sr();
    sb({cdr_pkg::SLAVE_ADDR_HI, ~asel, 1'h0}, 1'h1);
    sp();
    chk({7'h00, cdr_if_i.scl, cdr_if_i.sda}, 9'h003);
    sr();
    sb(aw, 1'h0);
    sb(8'h07, 1'h1);
    sp();
    asel <= 1'h1;
    sr();
    sb(aw, 1'h0);
    sb(8'h08, 1'h0);
    sb(8'h00, 1'h0);
    sb(8'h10, 1'h0);
    sb(8'h04, 1'h0);
    sp();
    rhead(8'h08);
    rb(1'h0, 8'h00);
    rb(1'h0, 8'h10);
    rb(1'h1, 8'h04);
    sp();
    rhead(8'h1E);
    rb(1'h0, 8'h02);
    rb(1'h0, 8'h02);
    rb(1'h1, 8'h02);
    sp();
    // second reset in mid-run: registers fall back, pin shows live lock again
    do_reset();
    repeat (10) @(posedge clk_sys_in);
    chk({8'h00, lli}, 9'h000);
    rhead(8'h09);
    rb(1'h1, 8'h00);
    sp();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
